// ---- logic/rdac_pkg.sv ----
`default_nettype none
// =============================================================
// Register map and field layout
package rdac_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] CONTROL_ADDR = 4'h0;
    localparam logic [3:0] LEVEL_ADDR   = 4'h1;
    localparam logic [3:0] STATUS_ADDR  = 4'h2;
    // Control register fields
    localparam int EN_BIT   = 7;
    localparam int LPS_BIT  = 6;
    localparam int OE_BIT   = 5;
    localparam int PSS_HI   = 3;
    localparam int PSS_LO   = 2;
    localparam int NSS_BIT  = 0;
    localparam logic [7:0] CONTROL_MASK  = 8'hED;
    localparam logic [7:0] LEVEL_MASK    = 8'h1F;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET   = 8'h00;
    localparam int LEVEL_W = 5;
    localparam int LEVEL_STEPS = 32;
    // Positive source encodings
    localparam logic [1:0] PSS_SUPPLY  = 2'h0;
    localparam logic [1:0] PSS_EXT_REF = 2'h1;
    localparam logic [1:0] PSS_FIXED   = 2'h2;
    localparam logic [1:0] PSS_RSVD    = 2'h3;
endpackage : rdac_pkg
`default_nettype wire

// ---- logic/rdac_regs_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Register image passed from the bus slave to the steering logic
interface rdac_regs_if;
    logic [7:0] control;
    logic [7:0] level;
    modport owner (output control, output level);
    modport user  (input control, input level);
endinterface : rdac_regs_if
`default_nettype wire

// ---- logic/rdac_regfile.sv ----
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Register storage for the two control registers
module rdac_regfile (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [3:0]       addr,
    input  wire logic [7:0]       wdata,
    input  wire logic             wr,
    rdac_regs_if.owner            regs
);
    logic [7:0] control_reg;
    logic [7:0] level_reg;
    wire        wr_control = wr && (addr == rdac_pkg::CONTROL_ADDR);
    wire        wr_level   = wr && (addr == rdac_pkg::LEVEL_ADDR);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= rdac_pkg::CONTROL_RESET;
            level_reg   <= rdac_pkg::LEVEL_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= wdata & rdac_pkg::CONTROL_MASK;
            end
            if (wr_level) begin
                level_reg <= wdata & rdac_pkg::LEVEL_MASK;
            end
        end
    end

    assign regs.control = control_reg;
    assign regs.level   = level_reg;
endmodule : rdac_regfile
`default_nettype wire

// ---- logic/rdac_ctrl.sv ----
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// =============================================================
module rdac_ctrl (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [7:0]            reg_rdata,
    input  wire logic             sleep_active,
    input  wire logic             pin_digital_in,
    output logic                  pin_digital_in_gated,
    output logic                  pin_digital_out_override,
    output logic                  converter_enable,
    output logic                  reference_output_pin,
    output logic                  pos_src_supply_sel,
    output logic                  pos_src_ext_ref_sel,
    output logic                  pos_src_fixed_sel,
    output logic                  pos_src_connect,
    output logic                  neg_src_ground_sel,
    output logic                  neg_src_ext_ref_sel,
    output logic                  neg_src_connect,
    output logic [4:0]            ladder_step,
    output logic                  pos_src_reserved
);
    // =============================================================
    // Reset release
    logic rst_sync1_reg;
    logic rst_n_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_reg <= 1'b0;
            rst_n_reg     <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n_reg     <= rst_sync1_reg;
        end
    end

    // =============================================================
    // Pin input synchronisers (pin and sleep come from outside)
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic sleep_s1_reg;
    logic sleep_s2_reg;
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_s1_reg   <= 1'b0;
            pin_s2_reg   <= 1'b0;
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg   <= pin_digital_in;
            pin_s2_reg   <= pin_s1_reg;
            sleep_s1_reg <= sleep_active;
            sleep_s2_reg <= sleep_s1_reg;
        end
    end

    // =============================================================
    // Register storage
    rdac_regs_if regs ();
    rdac_regfile u_regfile (
        .clk_sys (clk_sys),
        .rst_n   (rst_n_reg),
        .addr    (reg_addr),
        .wdata   (reg_wdata),
        .wr      (reg_wr),
        .regs    (regs)
    );

    // =============================================================
    // Field decode
    wire       en_bit  = regs.control[rdac_pkg::EN_BIT];
    wire       lps_bit = regs.control[rdac_pkg::LPS_BIT];
    wire       oe_bit  = regs.control[rdac_pkg::OE_BIT];
    wire [1:0] pss     = regs.control[rdac_pkg::PSS_HI:rdac_pkg::PSS_LO];
    wire       nss_bit = regs.control[rdac_pkg::NSS_BIT];
    // Sleep state is only visible in status, it alters no stored bit
    wire [7:0] status_word = {7'h00, sleep_s2_reg};

    // Read mux, unmapped reads as zero
    wire [7:0] rd_mux =
        (reg_addr == rdac_pkg::CONTROL_ADDR) ? regs.control :
        (reg_addr == rdac_pkg::LEVEL_ADDR)   ? regs.level   :
        (reg_addr == rdac_pkg::STATUS_ADDR)  ? status_word  : 8'h00;

    // =============================================================
    // Analog steering registers
    logic [7:0] rdata_reg;
    logic       en_reg;
    logic       oe_reg;
    logic [2:0] psel_reg;
    logic [1:0] nsel_reg;
    logic       pconn_reg;
    logic       nconn_reg;
    logic [4:0] step_reg;
    logic       rsvd_reg;
    logic       din_reg;

    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rdata_reg <= 8'h00;
        end else begin
            // Data stands one cycle after the read strobe only
            rdata_reg <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Next values, decoded from the register image
    // positive and negative source decode
    wire [2:0] psel_next = {pss == rdac_pkg::PSS_FIXED,
                            pss == rdac_pkg::PSS_EXT_REF,
                            pss == rdac_pkg::PSS_SUPPLY};
    wire       rsvd_next = (pss == rdac_pkg::PSS_RSVD);
    wire [1:0] nsel_next = {nss_bit, ~nss_bit};
    // Driven pin never echoes its own level back to software
    wire       din_next  = oe_bit ? 1'b0 : pin_s2_reg;

    // Converter enable and pin connection
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            en_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            en_reg <= en_bit;
            oe_reg <= oe_bit;
        end
    end

    // Ladder step
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            step_reg <= 5'h00;
        end else begin
            step_reg <= regs.level[rdac_pkg::LEVEL_W-1:0];
        end
    end

    // Source selection; reserved code selects nothing rather than a guess
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            psel_reg <= 3'h0;
            nsel_reg <= 2'h0;
            rsvd_reg <= 1'b0;
        end else begin
            psel_reg <= psel_next;
            rsvd_reg <= rsvd_next;
            nsel_reg <= nsel_next;
        end
    end

    // Ladder ends; both open in reset so no current flows before setup
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pconn_reg <= 1'b0;
            nconn_reg <= 1'b0;
        end else begin
            pconn_reg <= lps_bit;
            nconn_reg <= ~lps_bit;
        end
    end

    // Gated pin input, already two flops past the pin
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            din_reg <= 1'b0;
        end else begin
            din_reg <= din_next;
        end
    end

    // =============================================================
    // Outputs
    assign reg_rdata                = rdata_reg;
    assign converter_enable         = en_reg;
    assign reference_output_pin     = oe_reg;
    assign pin_digital_out_override = oe_reg;
    assign pin_digital_in_gated     = din_reg;
    assign pos_src_supply_sel       = psel_reg[0];
    assign pos_src_ext_ref_sel      = psel_reg[1];
    assign pos_src_fixed_sel        = psel_reg[2];
    assign pos_src_reserved         = rsvd_reg;
    assign pos_src_connect          = pconn_reg;
    assign neg_src_ground_sel       = nsel_reg[0];
    assign neg_src_ext_ref_sel      = nsel_reg[1];
    assign neg_src_connect          = nconn_reg;
    assign ladder_step              = step_reg;
endmodule : rdac_ctrl
`default_nettype wire

// ---- test/rdac_ctrl_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checks for the control block
module rdac_chk (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       converter_enable,
    input wire logic       reference_output_pin,
    input wire logic       pin_digital_out_override,
    input wire logic       pin_digital_in_gated,
    input wire logic       pos_src_connect,
    input wire logic       neg_src_connect,
    input wire logic       pos_src_supply_sel,
    input wire logic       pos_src_reserved,
    input wire logic       neg_src_ext_ref_sel,
    input wire logic [4:0] ladder_step
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Lone write, so outputs settle two edges on
    sequence s_cw;
        reg_wr && reg_addr == 4'h0 ##1 !(reg_wr && reg_addr == 4'h0);
    endsequence
    sequence s_lw;
        reg_wr && reg_addr == 4'h1 ##1 !(reg_wr && reg_addr == 4'h1);
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_ctrl_gaps: assert property (
        $past(reg_rd && reg_addr == 4'h0) |-> (reg_rdata & 8'h12) == 8'h00)
        else $error("control gap bits set");
    chk_level_gaps: assert property (
        $past(reg_rd && reg_addr == 4'h1) |-> (reg_rdata & 8'hE0) == 8'h00)
        else $error("level gap bits set");
    chk_enable_follow: assert property (
        s_cw |=> converter_enable == $past(reg_wdata[7], 2)
              && reference_output_pin == $past(reg_wdata[5], 2))
        else $error("enable or pin not following");
    chk_source_code: assert property (
        s_cw |=> pos_src_reserved == ($past(reg_wdata[3:2], 2) == 2'h3)
              && pos_src_supply_sel == ($past(reg_wdata[3:2], 2) == 2'h0)
              && neg_src_ext_ref_sel == $past(reg_wdata[0], 2))
        else $error("source select wrong");
    chk_lps_split: assert property (
        s_cw |=> pos_src_connect == $past(reg_wdata[6], 2)
              && neg_src_connect != pos_src_connect)
        else $error("ladder source split wrong");
    chk_pin_override: assert property (
        pin_digital_out_override == reference_output_pin
        && !(reference_output_pin && pin_digital_in_gated))
        else $error("pin override wrong");
    chk_level_step: assert property (
        s_lw |=> ladder_step == $past(reg_wdata[4:0], 2))
        else $error("ladder step not following");
    // Internal reset still holds for two edges after the pin rises
    chk_reset_clear: assert property (
        $rose(arst_n) |-> !converter_enable && !reference_output_pin && ladder_step == 5'h00)
        else $error("outputs not cleared by reset");
    cover property (s_cw);
    cover property (reg_rd ##1 reg_rdata != 8'h00);
    cover property (pos_src_reserved);
    cover property (s_lw ##1 ladder_step != 5'h00);
endmodule // rdac_chk
bind rdac_ctrl rdac_chk rdac_chk_inst (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .converter_enable, .reference_output_pin, .pin_digital_out_override,
    .pin_digital_in_gated, .pos_src_connect, .neg_src_connect, .pos_src_supply_sel,
    .pos_src_reserved, .neg_src_ext_ref_sel, .ladder_step);
`default_nettype wire

// ---- test/rdac_ctrl_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Register-level bench for the control block
module rdac_ctrl_tb_top;
    logic        clk_sys, arst_n, reg_wr, reg_rd, sleep_active, pin_in;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, v;
    wire  [7:0]  reg_rdata;
    wire  [16:0] outs;
    int          n_mismatch = 0, n_tests = 0;
    rdac_ctrl rdac_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_active(sleep_active), .pin_digital_in(pin_in),
        .converter_enable(outs[16]), .reference_output_pin(outs[15]),
        .pin_digital_out_override(outs[14]), .pin_digital_in_gated(outs[13]),
        .pos_src_connect(outs[12]), .neg_src_connect(outs[11]),
        .pos_src_supply_sel(outs[10]), .pos_src_ext_ref_sel(outs[9]),
        .pos_src_fixed_sel(outs[8]), .pos_src_reserved(outs[7]),
        .neg_src_ground_sel(outs[6]), .neg_src_ext_ref_sel(outs[5]), .ladder_step(outs[4:0]));
    // ==========================================
    // Clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Steering outputs expected from both register values
    function automatic logic [16:0] expo(input logic [7:0] c, input logic [7:0] l);
        return {c[7], c[5], c[5], ~c[5] & pin_in, c[6], ~c[6], c[3:2] == 2'h0, c[3:2] == 2'h1,
                c[3:2] == 2'h2, c[3:2] == 2'h3, ~c[0], c[0], l[4:0]};
    endfunction
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: read %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data only stands in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp_rd(reg_rdata, e);
    endtask
    task automatic chk(input logic [7:0] c, input logic [7:0] l);
        @(posedge clk_sys);
        #1 cmp(outs, expo(c, l));
    endtask
    task automatic final_report;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end
    // ==========================================
    // Main sequence
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, sleep_active, arst_n} = '0;
        pin_in = 1'b1;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        wr(4'h0, 8'hFF);
        chk(8'hED, 8'h00);
        rd(4'h0, 8'hED);
        for (int i = 0; i < 4; i++) begin
            v = {1'b1, i[0], 2'b00, i[1:0], 1'b0, i[0]};
            wr(4'h0, v);
            chk(v, 8'h00);
        end
        wr(4'h1, 8'hFF);
        chk(v, 8'h1F);
        rd(4'h1, 8'h1F);
        wr(4'h1, 8'h0A);
        chk(v, 8'h0A);
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        chk(8'h00, 8'h00);
        // Pin level must pass through while the pin is not driven
        @(posedge clk_sys);
        pin_in <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(8'h00, 8'h00);
        // Converter off before sleep, other bits set to watch them hold
        wr(4'h0, 8'h65);
        sleep_active <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(4'h2, 8'h01);
        @(posedge clk_sys);
        sleep_active <= 1'b0;
        rd(4'h0, 8'h65);
        wr(4'hF, 8'hFF);
        wr(4'h2, 8'hFF);
        rd(4'hF, 8'h00);
        rd(4'h2, 8'h00);
        rd(4'h0, 8'h65);
        wr(4'h1, 8'h1F);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        #1 cmp(outs, 17'h00000);
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        chk(8'h00, 8'h00);
        final_report();
    end
endmodule // rdac_ctrl_tb_top
`default_nettype wire
